//--- uer_bitclk.sv
`timescale 1ns/1ps
`default_nettype none
module uer_bitclk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic powerOn,
  input wire logic [3:0] baseSel,
  // Base clock enable
  output logic baseTick
);
  logic [uer_pkg::ACC_W-1:0] acc;
  logic [uer_pkg::SEL_MAX-1:0] pre;
  logic periphTick;
  wire [uer_pkg::ACC_W-1:0] accSum = acc + uer_pkg::ACC_STEP;
  wire accWrap = accSum >= uer_pkg::ACC_WRAP;
  wire [3:0] selEff = (baseSel > 4'(uer_pkg::SEL_MAX)) ? 4'(uer_pkg::SEL_MAX) : baseSel;
  wire [uer_pkg::SEL_MAX-1:0] preMax = uer_pkg::SEL_MAX'((9'h001 << selEff) - 9'h001);

  // Fractional accumulator gives an exact average peripheral rate, with ticks 15 or 16 cycles apart
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      acc <= '0;
      periphTick <= 1'b0;
    end
    else
    begin
      acc <= accWrap ? accSum - uer_pkg::ACC_WRAP : accSum;
      periphTick <= accWrap;
    end
  end

  // Power-of-two prescaler; held cleared while the port is off
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pre <= '0;
      baseTick <= 1'b0;
    end
    else if (!powerOn)
    begin
      pre <= '0;
      baseTick <= 1'b0;
    end
    else
    begin
      baseTick <= periphTick && (pre == preMax);
      if (periphTick)
        pre <= (pre == preMax) ? '0 : pre + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- uer_pkg.sv
package uer_pkg;
  // Clock rates in kHz; the peripheral clock is made from clk_sys
  localparam int SYS_KHZ = 125000;
  localparam int PERIPH_KHZ = 8000;
  localparam int ACC_W = 18; // Holds accumulator plus step without wrapping
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(PERIPH_KHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(SYS_KHZ);
  localparam int SEL_MAX = 8;

  // Register word indexes on the bus
  localparam logic [3:0] REG_BASE_SEL = 4'h0;
  localparam logic [3:0] REG_BAUD_DIV = 4'h1;
  localparam logic [3:0] REG_MODE = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_TX_HOLD = 4'h4;
  localparam logic [3:0] REG_RX_HOLD = 4'h5;
  localparam logic [3:0] REG_TX_STAT = 4'h6;
  localparam logic [3:0] REG_RX_ERR = 4'h7;
  localparam logic [3:0] REG_ISC = 4'h8;
  localparam logic [3:0] REG_RESP = 4'h9;

  // Reset values
  localparam logic [3:0] BASE_SEL_RST = 4'h0;
  localparam logic [7:0] BAUD_DIV_RST = 8'hFF;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h02;

  // Mode register fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam int MODE_ISRM = 0;
  localparam logic [1:0] PS_NONE = 2'h0;
  localparam logic [1:0] PS_ZERO = 2'h1;
  localparam logic [1:0] PS_ODD = 2'h2;
  localparam logic [1:0] PS_EVEN = 2'h3;

  // Control, status, switch and responder fields
  localparam int CTRL_LSB_FIRST = 1;
  localparam int CTRL_INVERT = 0;
  localparam int TXST_FULL = 1;
  localparam int TXST_BUSY = 0;
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;
  localparam int ISC_INTP = 0;
  localparam int ISC_TMR = 1;
  localparam int RESP_EN = 0;
  localparam int RESP_CNT_LSB = 4;

  // Reply characters
  localparam logic [7:0] CH_UT = 8'h54;
  localparam logic [7:0] CH_LT = 8'h74;
  localparam logic [7:0] CH_UO = 8'h4F;
  localparam logic [7:0] CH_UK = 8'h4B;
  localparam logic [7:0] CH_LO = 8'h6F;
  localparam logic [7:0] CH_LK = 8'h6B;
  localparam logic [7:0] CH_UU = 8'h55;
  localparam logic [7:0] CH_UC = 8'h43;
  localparam logic [7:0] CH_UP = 8'h50;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [7:0] CH_UE = 8'h45;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;

  // Ring of received entries
  localparam int RING_DEPTH = 4;
  localparam int RING_AW = 2;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_LOAD = 3'b010,
    RS_SEND = 3'b100
  } uer_resp_t;
endpackage

//--- uer_term_model.sv
`timescale 1ns/1ps
`default_nettype none
module uer_term_model #(
  parameter int BIT_CLKS = 250
) (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  output logic termTx,
  input wire logic termRx,
  // Received character
  output logic gotStrobe,
  output logic [7:0] gotByte,
  output logic gotParOk
);
  logic [8:0] sh;

  // Idle bit first, so a bad stop bit is still followed by a clean start edge
  task automatic send(input logic [6:0] ch, input logic badPar, input logic badStop);
    logic [10:0] fr;
    fr = {~badStop, ^ch ^ badPar, ch, 1'b0, 1'b1};
    for (int i = 0; i < 11; i++)
    begin
      termTx <= fr[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    termTx <= 1'b1;
  endtask

  // Mid-bit sampling, so a wrong bit rate garbles the character
  initial
  begin
    termTx = 1'b1; // Line idles high before the first frame
    gotStrobe = 1'b0;
    gotByte = 8'h00;
    gotParOk = 1'b0;
    forever
    begin
      @(negedge termRx);
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BIT_CLKS) @(posedge clk_sys);
        sh[i] = termRx;
      end
      gotByte <= {1'b0, sh[6:0]};
      gotParOk <= ~^sh[7:0] & sh[8];
      gotStrobe <= 1'b1;
      @(posedge clk_sys);
      gotStrobe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- uer_top.sv
`timescale 1ns/1ps
`default_nettype none
module uer_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial pins
  input wire logic serialInPin,
  output logic serialOutPin,
  // Events and routed input
  output logic rxDoneIrq,
  output logic rxErrorIrq,
  output logic txDoneIrq,
  output logic extIrqZero,
  output logic timerEventIn
);
  logic [3:0] baseSel;
  logic [7:0] baudDiv, modeReg, ctrlReg;
  logic [1:0] iscReg;
  logic respEn, baseTick, txEnQ, rxEnQ;
  logic [7:0] txHold, rxHold;
  logic txFull, txBusy, txLvl, txHalf;
  logic [10:0] txShift;
  logic [3:0] txBits, rxIdx;
  logic [7:0] txCnt, rxCnt, rxSh;
  logic rxS1, rxS2, rxInQ, rxAct, rxPhase, rxPar, rxFull, rxEvt;
  logic [2:0] rxErr;
  logic [7:0] ring [uer_pkg::RING_DEPTH];
  logic [uer_pkg::RING_AW-1:0] wrPtr, rdPtr;
  logic [uer_pkg::RING_AW:0] ringCnt;
  logic [7:0] curEntry;
  logic [1:0] byteIdx;
  uer_pkg::uer_resp_t rState;
  logic [31:0] rdMux;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev8[i] = v[7-i];
  endfunction

  // Four-byte reply for one ring entry
  function automatic logic [7:0] replyByte(input logic [7:0] e, input logic [1:0] i);
    logic [7:0] first, second;
    first = uer_pkg::CH_UU;
    second = uer_pkg::CH_UC;
    if (e[7])
    begin
      second = uer_pkg::CH_UE;
      if (e[uer_pkg::ERR_OVE]) first = uer_pkg::CH_UO;
      else if (e[uer_pkg::ERR_FE]) first = uer_pkg::CH_UF;
      else first = uer_pkg::CH_UP;
    end
    else if (e == uer_pkg::CH_UT)
    begin
      first = uer_pkg::CH_UO;
      second = uer_pkg::CH_UK;
    end
    else if (e == uer_pkg::CH_LT)
    begin
      first = uer_pkg::CH_LO;
      second = uer_pkg::CH_LK;
    end
    case (i)
      2'h0: replyByte = first;
      2'h1: replyByte = second;
      2'h2: replyByte = uer_pkg::CH_CR;
      default: replyByte = uer_pkg::CH_LF;
    endcase
  endfunction

  // Mode and control decode
  wire powerOn = modeReg[uer_pkg::MODE_POWER];
  wire [1:0] parSel = modeReg[uer_pkg::MODE_PS_HI:uer_pkg::MODE_PS_LO];
  wire len8 = modeReg[uer_pkg::MODE_CL];
  wire stop2 = modeReg[uer_pkg::MODE_SL];
  wire isrm = modeReg[uer_pkg::MODE_ISRM];
  wire hasPar = parSel != uer_pkg::PS_NONE;
  wire lsbFirst = ctrlReg[uer_pkg::CTRL_LSB_FIRST];
  wire invOut = ctrlReg[uer_pkg::CTRL_INVERT];

  // Bus decode; access completes on the cycle waitrequest is low
  wire reqOn = avs_read | avs_write;
  wire wrAcc = avs_write & ~avs_waitrequest;
  wire rdAcc = avs_read & ~avs_waitrequest;
  wire swTxWr = wrAcc && (avs_address == uer_pkg::REG_TX_HOLD);
  wire swRxRd = rdAcc && (avs_address == uer_pkg::REG_RX_HOLD);
  wire respWr = (rState == uer_pkg::RS_SEND) && !txFull && !swTxWr;
  wire [7:0] respByte = replyByte(curEntry, byteIdx);

  // Transmit frame build: data, parity (or stop filler), stop bits
  wire [7:0] txData = lsbFirst ? txHold : rev8(txHold);
  wire [7:0] txDm = len8 ? txData : {1'b0, txData[6:0]};
  wire txPar = (parSel == uer_pkg::PS_EVEN) ? ^txDm :
               (parSel == uer_pkg::PS_ODD) ? ~^txDm : 1'b0;
  wire txParBit = hasPar ? txPar : 1'b1;
  wire [10:0] txFrame = len8 ? {2'b11, txParBit, txDm} : {3'b111, txParBit, txDm[6:0]};
  wire [3:0] txCount = 4'(len8 ? 8 : 7) + 4'(hasPar) + 4'h1 + 4'(stop2);
  wire txTick = baseTick && (txCnt >= baudDiv - 8'h01);
  wire txLoad = !txBusy && txFull && txEnQ && baseTick;
  wire txEnd = txBusy && txTick && txHalf;

  // Receive decode
  wire rxIn = powerOn ? rxS2 : 1'b1;
  wire rxTick = baseTick && (rxCnt >= baudDiv - 8'h01);
  wire rxSample = rxAct && rxTick && !rxPhase;
  wire [3:0] rxDataEnd = len8 ? 4'h8 : 4'h7;
  wire [3:0] rxStopIdx = rxDataEnd + 4'h1 + 4'(hasPar);
  wire rxStart = !rxAct && rxEnQ && !rxIn && rxInQ; // Edge only; a low stop bit cannot restart
  wire rxDone = rxSample && (rxIdx == rxStopIdx);
  wire [7:0] rxAsm = len8 ? rxSh : {1'b0, rxSh[7:1]};
  wire [7:0] rxVal = lsbFirst ? rxAsm : rev8(rxAsm);
  wire rxPe = ((parSel == uer_pkg::PS_EVEN) && rxPar) ||
              ((parSel == uer_pkg::PS_ODD) && !rxPar);
  wire rxFe = !rxIn;
  wire rxOve = rxFull;
  wire rxAnyErr = rxPe || rxFe || rxOve;
  wire ringPush = rxEvt && respEn && (ringCnt < (uer_pkg::RING_AW+1)'(uer_pkg::RING_DEPTH));
  wire ringPop = rState == uer_pkg::RS_LOAD;

  uer_bitclk uBitclk (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .powerOn(powerOn),
    .baseSel(baseSel),
    .baseTick(baseTick)
  );

  // Register read selection; unmapped words read zero
  always_comb
  begin
    rdMux = '0;
    case (avs_address)
      uer_pkg::REG_BASE_SEL: rdMux[3:0] = baseSel;
      uer_pkg::REG_BAUD_DIV: rdMux[7:0] = baudDiv;
      uer_pkg::REG_MODE: rdMux[7:0] = modeReg;
      uer_pkg::REG_CTRL: rdMux[7:0] = ctrlReg;
      uer_pkg::REG_RX_HOLD: rdMux[7:0] = rxHold;
      uer_pkg::REG_TX_STAT: rdMux[1:0] = {txFull, txBusy};
      uer_pkg::REG_RX_ERR: rdMux[2:0] = rxErr;
      uer_pkg::REG_ISC: rdMux[1:0] = iscReg;
      uer_pkg::REG_RESP:
      begin
        rdMux[uer_pkg::RESP_EN] = respEn;
        rdMux[uer_pkg::RESP_CNT_LSB +: uer_pkg::RING_AW+1] = ringCnt;
      end
      default: rdMux = '0;
    endcase
  end

  // One wait state, then the answer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end
    else
    begin
      avs_waitrequest <= ~(reqOn & avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rdMux;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      baseSel <= uer_pkg::BASE_SEL_RST;
      baudDiv <= uer_pkg::BAUD_DIV_RST;
      modeReg <= uer_pkg::MODE_RST;
      ctrlReg <= uer_pkg::CTRL_RST;
      iscReg <= '0;
      respEn <= 1'b0;
    end
    else if (wrAcc)
    begin
      case (avs_address)
        uer_pkg::REG_BASE_SEL: baseSel <= avs_writedata[3:0];
        uer_pkg::REG_BAUD_DIV: baudDiv <= avs_writedata[7:0];
        uer_pkg::REG_MODE: modeReg <= avs_writedata[7:0];
        uer_pkg::REG_CTRL: ctrlReg <= avs_writedata[7:0];
        uer_pkg::REG_ISC: iscReg <= avs_writedata[1:0];
        uer_pkg::REG_RESP: respEn <= avs_writedata[uer_pkg::RESP_EN];
        default: ;
      endcase
    end
  end

  // Enables take effect on a base clock edge, as the port would see them
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      txEnQ <= 1'b0;
      rxEnQ <= 1'b0;
    end
    else if (!powerOn)
    begin
      txEnQ <= 1'b0;
      rxEnQ <= 1'b0;
    end
    else if (baseTick)
    begin
      txEnQ <= modeReg[uer_pkg::MODE_TXE];
      rxEnQ <= modeReg[uer_pkg::MODE_RXE];
    end
  end

  // Transmit holding register; a new write beats a same-cycle load
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      txHold <= '0;
      txFull <= 1'b0;
    end
    else if (!powerOn)
      txFull <= 1'b0;
    else if (swTxWr || respWr)
    begin
      txHold <= swTxWr ? avs_writedata[7:0] : respByte;
      txFull <= 1'b1;
    end
    else if (txLoad)
      txFull <= 1'b0;
  end

  // Transmit shifter; each bit lasts two divider periods
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      txBusy <= 1'b0;
      txLvl <= 1'b1;
      txShift <= '0;
      txBits <= '0;
      txCnt <= '0;
      txHalf <= 1'b0;
      txDoneIrq <= 1'b0;
    end
    else if (!powerOn)
    begin
      txBusy <= 1'b0;
      txLvl <= 1'b1;
      txCnt <= '0;
      txHalf <= 1'b0;
      txDoneIrq <= 1'b0;
    end
    else
    begin
      txDoneIrq <= txEnd && (txBits == 4'h0);
      if (txLoad)
      begin
        txBusy <= 1'b1;
        txLvl <= 1'b0;
        txShift <= txFrame;
        txBits <= txCount;
        txCnt <= '0;
        txHalf <= 1'b0;
      end
      else if (txBusy && baseTick)
      begin
        txCnt <= txTick ? 8'h00 : txCnt + 8'h01;
        if (txTick)
          txHalf <= ~txHalf;
        if (txEnd && txBits == 4'h0)
        begin
          txBusy <= 1'b0;
          txLvl <= 1'b1;
        end
        else if (txEnd)
        begin
          txLvl <= txShift[0];
          txShift <= {1'b1, txShift[10:1]};
          txBits <= txBits - 4'h1;
        end
      end
    end
  end

  // Pin input synchroniser and routed copies
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxInQ <= 1'b1;
      serialOutPin <= 1'b1;
      extIrqZero <= 1'b0;
      timerEventIn <= 1'b0;
    end
    else
    begin
      rxS1 <= serialInPin;
      rxS2 <= rxS1;
      rxInQ <= rxIn;
      serialOutPin <= powerOn ? (txLvl ^ invOut) : 1'b1;
      extIrqZero <= iscReg[uer_pkg::ISC_INTP] & rxS2;
      timerEventIn <= iscReg[uer_pkg::ISC_TMR] & rxS2;
    end
  end

  // Receive sequencer: samples at mid-bit, start bit re-checked
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rxAct <= 1'b0;
      rxCnt <= '0;
      rxPhase <= 1'b0;
      rxIdx <= '0;
      rxSh <= '0;
      rxPar <= 1'b0;
    end
    else if (!powerOn || !rxEnQ)
      rxAct <= 1'b0;
    else if (rxStart)
    begin
      rxAct <= 1'b1;
      rxCnt <= '0;
      rxPhase <= 1'b0;
      rxIdx <= '0;
      rxPar <= 1'b0;
    end
    else if (rxAct && baseTick)
    begin
      rxCnt <= rxTick ? 8'h00 : rxCnt + 8'h01;
      if (rxTick)
        rxPhase <= ~rxPhase;
      if (rxSample)
      begin
        rxIdx <= rxIdx + 4'h1;
        if (rxIdx == 4'h0 && rxIn)
          rxAct <= 1'b0;
        if (rxIdx != 4'h0 && rxIdx <= rxDataEnd)
          rxSh <= {rxIn, rxSh[7:1]};
        if (rxIdx != 4'h0 && rxIdx < rxStopIdx)
          rxPar <= rxPar ^ rxIn;
        if (rxDone)
          rxAct <= 1'b0;
      end
    end
  end

  // Completion: status, holding register and events
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rxErr <= '0;
      rxHold <= '0;
      rxFull <= 1'b0;
      rxEvt <= 1'b0;
      rxDoneIrq <= 1'b0;
      rxErrorIrq <= 1'b0;
    end
    else if (!powerOn)
    begin
      rxErr <= '0;
      rxHold <= '0;
      rxFull <= 1'b0;
      rxEvt <= 1'b0;
      rxDoneIrq <= 1'b0;
      rxErrorIrq <= 1'b0;
    end
    else
    begin
      rxEvt <= rxDone;
      rxDoneIrq <= rxDone && (!rxAnyErr || isrm);
      rxErrorIrq <= rxDone && rxAnyErr && !isrm;
      if (rxDone)
        rxErr <= {rxPe, rxFe, rxOve};
      if (rxDone && !rxOve)
      begin
        rxHold <= rxVal;
        rxFull <= 1'b1;
      end
      else if (swRxRd || (rxEvt && respEn))
        rxFull <= 1'b0;
    end
  end

  // Ring of entries; full ring drops the new one
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      ringCnt <= '0;
    end
    else
    begin
      if (ringPush)
        wrPtr <= wrPtr + 1'b1;
      ringCnt <= ringCnt + (uer_pkg::RING_AW+1)'(ringPush) - (uer_pkg::RING_AW+1)'(ringPop);
    end
  end

  // Entry storage; error status taken ahead of the data
  always_ff @(posedge clk_sys)
  begin
    if (ringPush)
      ring[wrPtr] <= (rxErr != 3'h0) ? {5'h10, rxErr} : {1'b0, rxHold[6:0]};
  end

  // Reply engine: waits on buffer-full before each byte
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rState <= uer_pkg::RS_IDLE;
      rdPtr <= '0;
      curEntry <= '0;
      byteIdx <= '0;
    end
    else
    begin
      case (rState)
        uer_pkg::RS_IDLE:
          if (ringCnt != '0)
            rState <= uer_pkg::RS_LOAD;
        uer_pkg::RS_LOAD:
        begin
          curEntry <= ring[rdPtr];
          rdPtr <= rdPtr + 1'b1;
          byteIdx <= '0;
          rState <= uer_pkg::RS_SEND;
        end
        uer_pkg::RS_SEND:
          if (respWr)
          begin
            byteIdx <= byteIdx + 2'h1;
            if (byteIdx == 2'h3)
              rState <= uer_pkg::RS_IDLE;
          end
        default: rState <= uer_pkg::RS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- uer_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module uer_top_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and events
  input wire logic serialInPin,
  input wire logic serialOutPin,
  input wire logic rxDoneIrq,
  input wire logic rxErrorIrq,
  input wire logic txDoneIrq,
  input wire logic extIrqZero,
  input wire logic timerEventIn
);
  logic [15:0] lowRun;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Low stretch length; a low run must last at least 240 cycles before the pin rises
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      lowRun <= 16'h0000;
    else
      lowRun <= serialOutPin ? 16'h0000 : lowRun + 16'h0001;
  end

  // Bus answers after exactly one wait state
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus wait state wrong");

  property p_errstat_ro;
    avs_read && !avs_waitrequest && avs_address == 4'h7 |-> avs_readdata[31:3] == 29'h0;
  endproperty
  a_errstat_ro: assert property (p_errstat_ro) else $error("error status too wide");

  property p_done_pulse;
    rxDoneIrq |=> !rxDoneIrq;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");

  property p_err_pulse;
    rxErrorIrq |=> !rxErrorIrq;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");

  property p_irq_excl;
    !(rxDoneIrq && rxErrorIrq);
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("done and error together");

  property p_ext_route;
    extIrqZero |-> $past(serialInPin, 3);
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("routed input not gated");

  property p_fall_gates;
    $fell(serialInPin) |-> ##3 !(extIrqZero || timerEventIn);
  endproperty
  a_fall_gates: assert property (p_fall_gates) else $error("routed input late");

  property p_bit_width;
    $rose(serialOutPin) |-> lowRun >= 16'h00F0;
  endproperty
  a_bit_width: assert property (p_bit_width) else $error("output bit too short");

  property p_txdone_idle;
    txDoneIrq |-> serialOutPin ##1 !txDoneIrq;
  endproperty
  a_txdone_idle: assert property (p_txdone_idle) else $error("frame end wrong");
endmodule

bind uer_top uer_top_monitor u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serialInPin(serialInPin), .serialOutPin(serialOutPin), .rxDoneIrq(rxDoneIrq),
  .rxErrorIrq(rxErrorIrq), .txDoneIrq(txDoneIrq), .extIrqZero(extIrqZero),
  .timerEventIn(timerEventIn)
);
`default_nettype wire

//--- uer_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uer_top_tb;
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, serialInPin, serialOutPin;
  logic rxDoneIrq, rxErrorIrq, txDoneIrq, extIrqZero, timerEventIn, gotStrobe, gotParOk;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed, rdv;
  logic rawRd;
  logic [7:0] gotByte;
  logic [6:0] c, c2;
  logic [7:0] serQ[$];
  logic [31:0] rdQ[$];
  int errors, checks, cycles, doneCnt, errCnt;

  uer_top dut (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .rxDoneIrq(rxDoneIrq), .rxErrorIrq(rxErrorIrq),
    .txDoneIrq(txDoneIrq), .extIrqZero(extIrqZero), .timerEventIn(timerEventIn)
  );
  uer_term_model term (
    .clk_sys(clk_sys), .termTx(serialInPin), .termRx(serialOutPin),
    .gotStrobe(gotStrobe), .gotByte(gotByte), .gotParOk(gotParOk)
  );

  // 125 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Event counts, hang limit, and oldest-note compares as results appear
  always @(posedge clk_sys)
  begin
    cycles++;
    doneCnt += int'(rxDoneIrq === 1'b1);
    errCnt += int'(rxErrorIrq === 1'b1);
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && !rawRd)
      chk(avs_readdata, rdQ.pop_front());
    if (gotStrobe === 1'b1)
      chk(32'({gotParOk, gotByte}), 32'({1'b1, serQ.pop_front()}));
    if (cycles == 99000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  function automatic logic [6:0] rch();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[6:0] ^ 7'(seed[6:0] == 7'h54 || seed[6:0] == 7'h74);
  endfunction

  // Request stands until waitrequest low; one idle edge keeps drivers apart
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rdv = avs_readdata;
    errors += int'(n == 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, 32'(d));
  endtask

  // Poll buffer-full before each software write; polls are not noted
  task automatic txw(input logic [7:0] d);
    rawRd = 1'b1;
    rdv = 32'h2;
    while (rdv[1])
      bus(1'b0, 4'h6, 32'h0);
    rawRd = 1'b0;
    serQ.push_back(d);
    wr(4'h4, d);
  endtask

  // Power first, then transmit, then receive
  task automatic pwr(input logic [7:0] m);
    wr(4'h2, m);
    wr(4'h2, m | 8'h80);
    wr(4'h2, m | 8'hC0);
    wr(4'h2, m | 8'hE0);
  endtask

  task automatic expect4(input logic [7:0] a, input logic [7:0] b);
    serQ.push_back(a);
    serQ.push_back(b);
    serQ.push_back(8'h0D);
    serQ.push_back(8'h0A);
  endtask

  initial
  begin
    nrst = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    seed = 32'h82CD7134;
    rawRd = 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 32'h0);
    rd(4'h1, 32'hFF);
    rd(4'h2, 32'h1);
    rd(4'h3, 32'h2);
    rd(4'h6, 32'h0);
    rd(4'hF, 32'h0);
    $display("test reset done");
    // Fastest legal rate keeps frames short: 16 base clocks per bit
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h08);
    pwr(8'h18);
    rd(4'h2, 32'hF8);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h8, 8'(i));
      repeat (4) @(posedge clk_sys);
      chk(32'({extIrqZero, timerEventIn}), 32'({i[0], i[1]}));
    end
    $display("test setup done");
    c = rch();
    term.send(c, 1'b0, 1'b0);
    chk(32'(doneCnt), 32'h1);
    rd(4'h7, 32'h0);
    rd(4'h5, 32'(c));
    c2 = rch();
    term.send(c2, 1'b0, 1'b0);
    term.send(rch(), 1'b0, 1'b0);
    chk(32'(errCnt), 32'h1);
    rd(4'h7, 32'h1);
    rd(4'h5, 32'(c2));
    term.send(rch(), 1'b1, 1'b0);
    rd(4'h7, 32'h4);
    wr(4'h2, 8'h18);
    rd(4'h7, 32'h0);
    rd(4'h5, 32'h0);
    pwr(8'h08);
    term.send(rch(), 1'b1, 1'b0);
    chk(32'(errCnt), 32'h2);
    rd(4'h7, 32'h0);
    wr(4'h2, 8'h18);
    pwr(8'h18);
    $display("test receive done");
    // Software sends back to back; enable settles for a base clock first
    repeat (20) @(posedge clk_sys);
    repeat (3) txw({1'b0, rch()});
    while (serQ.size() != 0) @(posedge clk_sys);
    while (txDoneIrq !== 1'b1) @(posedge clk_sys);
    rd(4'h6, 32'h0);
    $display("test transmit done");
    // Back-to-back characters queue up in the ring behind slow replies
    wr(4'h9, 8'h01);
    expect4(8'h4F, 8'h4B);
    term.send(7'h54, 1'b0, 1'b0);
    expect4(8'h6F, 8'h6B);
    term.send(7'h74, 1'b0, 1'b0);
    expect4(8'h55, 8'h43);
    term.send(rch(), 1'b0, 1'b0);
    expect4(8'h50, 8'h45);
    term.send(rch(), 1'b1, 1'b0);
    expect4(8'h46, 8'h45);
    term.send(rch(), 1'b0, 1'b1);
    while (serQ.size() != 0) @(posedge clk_sys);
    expect4(8'h46, 8'h45);
    term.send(rch(), 1'b1, 1'b1);
    while (serQ.size() != 0) @(posedge clk_sys);
    rd(4'h9, 32'h1);
    $display("test responder done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
